// >>> pulse_nco.sv
// Square wave generator whose frequency in Hz is given directly.
// Assumes freq_in is far below half the system clock.
`timescale 1ns/1ps
module pulse_nco
   import stop_pulse_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        enable_in,
   input  wire logic [13:0] freq_in,
   output logic             wave_out
);
   logic [25:0] acc_reg, acc_next;
   logic        wave_reg, wave_next;
   logic [25:0] sum;

   always_comb begin
      sum       = acc_reg + {12'h000, freq_in};
      acc_next  = sum;
      wave_next = wave_reg;
      if (!enable_in) begin
         acc_next  = '0;
         wave_next = 1'b0;
      end else if (sum >= 26'(HALF_CLK_HZ)) begin
         acc_next  = sum - 26'(HALF_CLK_HZ);
         wave_next = !wave_reg;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         acc_reg  <= '0;
         wave_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         wave_reg <= wave_next;
      end
   end

   assign wave_out = wave_reg;
endmodule : pulse_nco

// >>> pulse_output_and_counter_stop.sv
// Digital/pulse output selector and precise stop counter unit.
// Assumes all inputs synchronous to sys_clk_in; out_freq_in and freq_max_in in 0.01 Hz, pulse full scale and pulse frequency in Hz.
`timescale 1ns/1ps
module pulse_output_and_counter_stop (
   input  wire logic               sys_clk_in,
   input  wire logic               rst_in,
   input  wire logic [5:0]         out_func_sel_in,
   input  wire logic [13:0]        pulse_output_full_scale_in,
   input  wire logic [25:0]        status_cond_in,
   input  wire logic [15:0]        ctrl_word_in,
   input  wire logic signed [23:0] ref_in,
   input  wire logic signed [23:0] ref_min_in,
   input  wire logic signed [23:0] ref_max_in,
   input  wire logic signed [23:0] fb_in,
   input  wire logic signed [23:0] fb_min_in,
   input  wire logic signed [23:0] fb_max_in,
   input  wire logic [23:0]        out_freq_in,
   input  wire logic [23:0]        freq_max_in,
   input  wire logic [23:0]        current_in,
   input  wire logic [23:0]        inv_current_in,
   input  wire logic [23:0]        power_in,
   input  wire logic [23:0]        motor_power_in,
   input  wire logic [7:0]         heatsink_temp_in,
   input  wire stop_pulse_pkg::stop_mode_t stop_mode_in,
   input  wire logic               start_in,
   input  wire logic               count_pulse_in,
   input  wire logic [19:0]        preset_count_in,
   input  wire logic [6:0]         comp_delay_ms_in,
   input  wire logic               standstill_in,
   output logic                    do46_out,
   output logic                    halt_out,
   output logic [19:0]             pulse_count_out,
   output logic [13:0]             pulse_freq_out
);
   import stop_pulse_pkg::*;
   default clocking chk_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   // Pulse output: range selection and scaling
   logic signed [24:0] qx, qlo, qhi, off, span;
   logic               pulse_mode;
   logic [13:0]        fs;
   logic [39:0]        sc_num, sc_den, sc_quot;
   logic               sc_busy, sc_done, cond_bit;
   logic [13:0]        freq_reg, freq_next;
   logic               do46_reg, do46_next, wave;

   always_comb begin
      fs = pulse_output_full_scale_in;
      if (fs < FS_MIN_HZ) fs = FS_MIN_HZ;
      if (fs > FS_MAX_HZ) fs = FS_MAX_HZ;
      qx  = '0;
      qlo = '0;
      qhi = 25'sd1;
      pulse_mode = 1'b1;
      unique case (out_func_sel_in)
         FN_PULSE_REF: begin
            qx  = 25'(ref_in);
            qlo = 25'(ref_min_in);
            qhi = 25'(ref_max_in);
         end
         FN_PULSE_FB: begin
            qx  = 25'(fb_in);
            qlo = 25'(fb_min_in);
            qhi = 25'(fb_max_in);
         end
         FN_OUTFREQ: begin
            qx  = {1'b0, out_freq_in};
            qhi = {1'b0, freq_max_in};
         end
         FN_CURRENT: begin
            qx  = {1'b0, current_in};
            qhi = {1'b0, inv_current_in};
         end
         FN_POWER: begin
            qx  = {1'b0, power_in};
            qhi = {1'b0, motor_power_in};
         end
         FN_TEMP: begin
            qx  = {17'h00000, heatsink_temp_in};
            qlo = TEMP_LO_C;
            qhi = TEMP_HI_C;
         end
         default: pulse_mode = 1'b0;
      endcase
      off  = qx - qlo;
      span = qhi - qlo;
      // Endpoints clamp by passing through the divider with a divisor of one; inside the range divide
      if (off <= 0 || span <= 0) begin
         sc_num = '0;
         sc_den = 40'h1;
      end else if (off >= span) begin
         sc_num = {26'h0, fs};
         sc_den = 40'h1;
      end else begin
         sc_num = 40'(off) * {26'h0, fs};
         sc_den = 40'(span);
      end
   end

   seq_divider #(.WIDTH(40)) scale_div (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .start_in   (!sc_busy),
      .num_in     (sc_num),
      .den_in     (sc_den),
      .busy_out   (sc_busy),
      .done_out   (sc_done),
      .quot_out   (sc_quot)
   );

   always_comb begin
      freq_next = freq_reg;
      if (sc_done) begin
         freq_next = sc_quot[13:0];
         if (sc_quot[13:0] < FREQ_FLOOR_HZ) freq_next = FREQ_FLOOR_HZ;
      end
   end

   pulse_nco nco (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .enable_in  (pulse_mode),
      .freq_in    (freq_reg),
      .wave_out   (wave)
   );

   always_comb begin
      cond_bit = 1'b0;
      if (out_func_sel_in <= FN_STATUS_LAST ||
          (out_func_sel_in > FN_PULSE_REF &&
           out_func_sel_in <= FN_STATUS2_END))
         cond_bit = status_cond_in[out_func_sel_in[4:0]];
      else if (out_func_sel_in == FN_CTRL_BIT)
         cond_bit = ctrl_word_in[CTRL_BIT_POS];
      else if (out_func_sel_in == FN_SLEEP)
         cond_bit = out_freq_in < SLEEP_CHZ;
      do46_next = pulse_mode ? wave : cond_bit;
   end

   // Precise stop unit
   stop_state_t state_reg, state_next;
   logic [19:0] count_reg, count_next, target_reg, target_next;
   logic [19:0] ramp_reg, ramp_next, carry_reg, carry_next, preset;
   logic [23:0] dly_reg, dly_next, dly_q_reg, dly_q_next, tsys;
   logic [47:0] dl_num, dl_den, dl_quot;
   logic        dl_busy, dl_done, halt_reg, halt_next;
   logic        pin_prev_reg, start_prev_reg, pin_edge, start_edge;
   logic        is_count, is_comp, clears, trigger;
   logic [6:0]  comp_ms;

   always_comb begin
      is_count = stop_mode_in inside {SM_COUNT_CLEAR, SM_COUNT_CARRY,
                                      SM_VEL_COUNT_CLR, SM_VEL_COUNT_CRY};
      is_comp  = stop_mode_in inside {SM_VEL_HALT, SM_VEL_COUNT_CLR,
                                      SM_VEL_COUNT_CRY};
      clears   = stop_mode_in inside {SM_COUNT_CLEAR, SM_VEL_COUNT_CLR};
      preset   = preset_count_in > PRESET_MAX ? PRESET_MAX
                                              : preset_count_in;
      comp_ms  = comp_delay_ms_in > COMP_MS_MAX ? COMP_MS_MAX
                                                : comp_delay_ms_in;
      tsys     = 24'(comp_ms * CYC_PER_MS);
      // Delay so that v*(d+Tsys) equals fmax*Tsys
      if (out_freq_in >= freq_max_in) begin
         dl_num = '0;
      end else begin
         dl_num = 48'(freq_max_in - out_freq_in) * {24'h0, tsys};
      end
      dl_den = out_freq_in == 24'h0 ? 48'h1 : {24'h0, out_freq_in};
      pin_edge   = count_pulse_in && !pin_prev_reg;
      start_edge = start_in && !start_prev_reg;
   end

   seq_divider #(.WIDTH(48)) delay_div (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .start_in   (!dl_busy),
      .num_in     (dl_num),
      .den_in     (dl_den),
      .busy_out   (dl_busy),
      .done_out   (dl_done),
      .quot_out   (dl_quot)
   );

   always_comb begin
      state_next  = state_reg;
      count_next  = count_reg;
      target_next = target_reg;
      ramp_next   = ramp_reg;
      carry_next  = carry_reg;
      dly_next    = dly_reg;
      dly_q_next  = dly_q_reg;
      if (dl_done)
         dly_q_next = |dl_quot[47:24] ? 24'hFFFFFF : dl_quot[23:0];
      trigger = !start_in || (is_count && count_reg >= target_reg);
      unique case (state_reg)
         ST_IDLE: begin
            if (start_edge) begin
               state_next  = ST_RUN;
               count_next  = '0;
               target_next = preset > carry_reg ? preset - carry_reg
                                                : '0;
            end
         end
         ST_RUN: begin
            if (pin_edge && count_reg != PRESET_MAX)
               count_next = count_reg + 1'b1;
            if (trigger) begin
               ramp_next = '0;
               if (is_comp) begin
                  state_next = ST_DELAY;
                  dly_next   = dly_q_reg;
               end else begin
                  state_next = ST_RAMP;
               end
            end
         end
         ST_DELAY: begin
            if (pin_edge) ramp_next = ramp_reg + 1'b1;
            if (dly_reg == '0) state_next = ST_RAMP;
            else dly_next = dly_reg - 1'b1;
         end
         ST_RAMP: begin
            if (pin_edge) ramp_next = ramp_reg + 1'b1;
            if (standstill_in) begin
               state_next = ST_IDLE;
               if (clears || !is_count)
                  carry_next = '0;
               else
                  carry_next = ramp_reg;
            end
         end
      endcase
      halt_next = state_next == ST_RAMP;
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_reg      <= ST_IDLE;
         count_reg      <= '0;
         target_reg     <= PRESET_DEFAULT;
         ramp_reg       <= '0;
         carry_reg      <= '0;
         dly_reg        <= '0;
         dly_q_reg      <= '0;
         halt_reg       <= 1'b0;
         pin_prev_reg   <= 1'b0;
         start_prev_reg <= 1'b0;
         freq_reg       <= FREQ_FLOOR_HZ;
         do46_reg       <= 1'b0;
      end else begin
         state_reg      <= state_next;
         count_reg      <= count_next;
         target_reg     <= target_next;
         ramp_reg       <= ramp_next;
         carry_reg      <= carry_next;
         dly_reg        <= dly_next;
         dly_q_reg      <= dly_q_next;
         halt_reg       <= halt_next;
         pin_prev_reg   <= count_pulse_in;
         start_prev_reg <= start_in;
         freq_reg       <= freq_next;
         do46_reg       <= do46_next;
      end
   end

   assign do46_out        = do46_reg;
   assign halt_out        = halt_reg;
   assign pulse_count_out = count_reg;
   assign pulse_freq_out  = freq_reg;

   // Checks
   sequence seq_start_edge;
      state_reg == ST_IDLE && start_in && !start_prev_reg;
   endsequence

   sequence seq_run_fresh;
      state_reg == ST_RUN && count_reg == '0;
   endsequence

   chk_freq_floor: assert property (
      freq_reg >= FREQ_FLOOR_HZ)
      else $error("pulse frequency below floor");

   chk_fs_ceiling: assert property (
      sc_done |=> freq_reg <= FS_MAX_HZ)
      else $error("pulse frequency above full scale");

   chk_ctrl_bit_out: assert property (
      out_func_sel_in == FN_CTRL_BIT |=> do46_out == $past(ctrl_word_in[12]))
      else $error("control word output mismatch");

   chk_sleep_out: assert property (
      out_func_sel_in == FN_SLEEP |=>
      do46_out == ($past(out_freq_in) < SLEEP_CHZ))
      else $error("sleep output mismatch");

   chk_status_level: assert property (
      out_func_sel_in <= FN_STATUS_LAST |=>
      do46_out == $past(status_cond_in[out_func_sel_in[4:0]]))
      else $error("status output mismatch");

   chk_count_start: assert property (
      seq_start_edge |=> seq_run_fresh)
      else $error("counting did not start on start edge");

   chk_preset_halt: assert property (
      state_reg == ST_RUN && is_count && !is_comp && count_reg >= target_reg
      |=> halt_out ##1 (halt_out || state_reg == ST_IDLE))
      else $error("preset reached without stop");

   chk_reset_clear: assert property (
      state_reg == ST_RAMP && standstill_in && clears |=> carry_reg == '0)
      else $error("ramp pulses not cleared");

   chk_carry_keep: assert property (
      state_reg == ST_RAMP && standstill_in && is_count && !clears
      |=> carry_reg == $past(ramp_reg))
      else $error("ramp pulses not carried");

   chk_delay_hold: assert property (
      state_reg == ST_DELAY && dly_reg != '0 |=> !halt_out)
      else $error("stop not delayed");
endmodule : pulse_output_and_counter_stop

// >>> pulse_output_and_counter_stop_tb_top.sv
// Bench: selector table, full-scale clamp, precise stop cycles.
// Assumes stop_pulse_pkg and pulse_partner are compiled first.
`timescale 1ns/1ps
module pulse_output_and_counter_stop_tb_top;
   import stop_pulse_pkg::*;
   typedef struct {
      logic [5:0]  sel;
      logic [25:0] cond;
      logic [15:0] ctrl;
      logic [23:0] x;
      logic [7:0]  temp;
      logic        is_f;
      logic [13:0] exp;
   } row_t;
   localparam int LIMIT = 95000;
   row_t rows [16] = '{
      '{6'h00, 26'h1, 16'h0, 24'h3E8, 8'h3C, 1'b0, 14'h1},
      '{6'h14, 26'hFFFFF, 16'h0, 24'h3E8, 8'h3C, 1'b0, 14'h0},
      '{6'h16, 26'h400000, 16'h0, 24'h3E8, 8'h3C, 1'b0, 14'h1},
      '{6'h19, 26'h2000000, 16'h0, 24'h3E8, 8'h3C, 1'b0, 14'h1},
      '{6'h1F, 26'h0, 16'h1000, 24'h3E8, 8'h3C, 1'b0, 14'h1},
      '{6'h1F, 26'h3FFFFFF, 16'hEFFF, 24'h3E8, 8'h3C, 1'b0, 14'h0},
      '{6'h20, 26'h0, 16'h0, 24'h9, 8'h3C, 1'b0, 14'h1},
      '{6'h20, 26'h0, 16'h0, 24'hA, 8'h3C, 1'b0, 14'h0},
      '{6'h28, 26'h3FFFFFF, 16'hFFFF, 24'h0, 8'h3C, 1'b0, 14'h0},
      '{6'h15, 26'h0, 16'h0, 24'h1F4, 8'h3C, 1'b1, 14'hEA6},
      '{6'h1A, 26'h0, 16'h0, 24'h7D0, 8'h3C, 1'b1, 14'h1388},
      '{6'h1B, 26'h0, 16'h0, 24'h0, 8'h3C, 1'b1, 14'h10},
      '{6'h1C, 26'h0, 16'h0, 24'hFA, 8'h3C, 1'b1, 14'h4E2},
      '{6'h1D, 26'h0, 16'h0, 24'h3E8, 8'h3C, 1'b1, 14'h1388},
      '{6'h1E, 26'h0, 16'h0, 24'h0, 8'h3C, 1'b1, 14'h9C4},
      '{6'h1E, 26'h0, 16'h0, 24'h0, 8'h0A, 1'b1, 14'h10}
   };
   logic        clk = 1'b0, rst = 1'b1, start = 1'b0, still = 1'b0;
   logic        do46, halt, pulse;
   logic [5:0]  sel = 6'h00;
   logic [13:0] fs = FS_DEFAULT_HZ, pf;
   logic [25:0] cond = 26'h0;
   logic [15:0] ctrl = 16'h0;
   logic [23:0] x = 24'h0, ofreq = 24'h0, fmax = 24'h3E8;
   logic [7:0]  temp = 8'h3C;
   logic [19:0] preset = PRESET_DEFAULT, cnt;
   logic [6:0]  ms = COMP_MS_DEFAULT;
   stop_mode_t  mode = SM_RAMP;
   int          error_cnt = 0, n_tests = 0, cyc = 0, rise, r0;

   pulse_output_and_counter_stop dut_u (
      .sys_clk_in(clk), .rst_in(rst), .out_func_sel_in(sel),
      .pulse_output_full_scale_in(fs), .status_cond_in(cond),
      .ctrl_word_in(ctrl), .ref_in(x), .ref_min_in(24'hFFFC18),
      .ref_max_in(fmax), .fb_in(x), .fb_min_in(24'h0), .fb_max_in(fmax),
      .out_freq_in(ofreq), .freq_max_in(fmax), .current_in(x),
      .inv_current_in(fmax), .power_in(x), .motor_power_in(fmax),
      .heatsink_temp_in(temp), .stop_mode_in(mode), .start_in(start),
      .count_pulse_in(pulse), .preset_count_in(preset),
      .comp_delay_ms_in(ms), .standstill_in(still), .do46_out(do46),
      .halt_out(halt), .pulse_count_out(cnt), .pulse_freq_out(pf)
   );
   pulse_partner par_u (
      .sys_clk_in(clk), .do46_in(do46),
      .count_pulse_out(pulse), .rise_cnt_out(rise)
   );

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic stop_test();
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   // One start, n counted pulses, stop, one ramp pulse, standstill
   task automatic run(input stop_mode_t m, input logic [19:0] pre,
                      input int n, input logic exp_h);
      mode = m;
      preset = pre;
      start = 1'b1; // Plain start level, no pulse-start function
      tick(2);
      par_u.burst(n);
      tick(3);
      check(halt, exp_h);
      if (exp_h) check(cnt, n);
      start = 1'b0;
      par_u.burst(1);
      check(halt, 1'b1);
      still = 1'b1;
      tick(2);
      check(halt, 1'b0);
      still = 1'b0;
      tick(2);
   endtask : run

   initial begin
      tick(2);
      check(do46, 1'b0);
      check(halt, 1'b0);
      check(cnt, 20'h0);
      check(pf, FREQ_FLOOR_HZ);
      rst = 1'b0;
      foreach (rows[i]) begin
         sel = rows[i].sel;
         cond = rows[i].cond;
         ctrl = rows[i].ctrl;
         x = rows[i].x;
         ofreq = rows[i].x;
         temp = rows[i].temp;
         tick(150);
         if (rows[i].is_f) begin
            check(pf, rows[i].exp);
         end else begin
            check(do46, rows[i].exp[0]);
         end
      end
      sel = FN_OUTFREQ;
      ofreq = fmax;
      fs = 14'h3FFF;
      tick(150);
      check(pf, FS_MAX_HZ);
      fs = 14'h0064;
      tick(150);
      check(pf, FS_MIN_HZ);
      fs = FS_MAX_HZ;
      tick(150);
      r0 = rise;
      tick(20000);
      check((rise - r0) inside {[1:3]}, 1'b1);
      fmax = 24'h44C;
      ofreq = 24'h3E8;
      ms = 7'h01;
      mode = SM_VEL_HALT;
      tick(150);
      start = 1'b1;
      tick(4);
      start = 1'b0;
      tick(9000);
      check(halt, 1'b0);
      tick(1100);
      check(halt, 1'b1);
      still = 1'b1;
      tick(2);
      still = 1'b0;
      tick(2);
      // System delay above 100 ms is clamped: 100 cycles, not 127
      fmax = 24'h0186A1;
      ofreq = 24'h0186A0;
      ms = 7'h7F;
      tick(150);
      start = 1'b1;
      tick(4);
      start = 1'b0;
      tick(95);
      check(halt, 1'b0);
      tick(10);
      check(halt, 1'b1);
      still = 1'b1;
      tick(2);
      still = 1'b0;
      tick(2);
      run(SM_COUNT_CLEAR, 20'h3, 3, 1'b1);
      run(SM_COUNT_CLEAR, 20'h3, 2, 1'b0);
      run(SM_COUNT_CARRY, 20'h3, 3, 1'b1);
      run(SM_COUNT_CARRY, 20'h3, 2, 1'b1);
      run(SM_RAMP, 20'h1, 1, 1'b0);
      fmax = 24'h3E8;
      tick(150);
      run(SM_VEL_HALT, 20'h1, 1, 1'b0);
      run(SM_VEL_COUNT_CLR, 20'h3, 3, 1'b1);
      run(SM_VEL_COUNT_CRY, 20'h3, 3, 1'b1);
      run(SM_VEL_COUNT_CRY, 20'h3, 2, 1'b1);
      stop_test();
   end
endmodule : pulse_output_and_counter_stop_tb_top

// >>> pulse_partner.sv
// Far-side model: pulse source on the count input, counter of output rises.
// Assumes the block samples its pulse input on rising clock edges.
`timescale 1ns/1ps
module pulse_partner #(
   parameter int HALF_CYC = 740
) (
   input  wire logic sys_clk_in,
   input  wire logic do46_in,
   output logic      count_pulse_out,
   output int        rise_cnt_out
);
   logic do46_q = 1'b0;
   initial count_pulse_out = 1'b0;
   initial rise_cnt_out = 0;
   // Counts rising edges seen on the frequency output
   always @(posedge sys_clk_in) begin
      if (do46_in === 1'b1 && do46_q === 1'b0) begin
         rise_cnt_out <= rise_cnt_out + 1;
      end
      do46_q <= do46_in;
   end
   // Pulse period of two half periods stays below the input rate limit
   task automatic burst(input int n);
      repeat (n) begin
         @(negedge sys_clk_in);
         count_pulse_out = 1'b1;
         repeat (HALF_CYC) @(negedge sys_clk_in);
         count_pulse_out = 1'b0;
         repeat (HALF_CYC) @(negedge sys_clk_in);
      end
   endtask : burst
endmodule : pulse_partner

// >>> seq_divider.sv
// Restoring sequential divider, one quotient bit per clock.
// Assumes a nonzero divisor; operands are latched on start.
`timescale 1ns/1ps
module seq_divider #(
   parameter int WIDTH = 40
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   input  wire logic             start_in,
   input  wire logic [WIDTH-1:0] num_in,
   input  wire logic [WIDTH-1:0] den_in,
   output logic                  busy_out,
   output logic                  done_out,
   output logic [WIDTH-1:0]      quot_out
);
   localparam int CW = $clog2(WIDTH + 1);
   logic [WIDTH:0]   rem_reg, rem_next;
   logic [WIDTH-1:0] quo_reg, quo_next, den_reg, den_next;
   logic [CW-1:0]    cnt_reg, cnt_next;
   logic             busy_reg, busy_next, done_reg, done_next;
   logic [WIDTH:0]   trial;

   always_comb begin
      rem_next  = rem_reg;
      quo_next  = quo_reg;
      den_next  = den_reg;
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      trial     = {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]};
      if (!busy_reg && start_in) begin
         rem_next  = '0;
         quo_next  = num_in;
         den_next  = den_in;
         cnt_next  = CW'(WIDTH);
         busy_next = 1'b1;
      end else if (busy_reg) begin
         if (trial >= {1'b0, den_reg}) begin
            rem_next = trial - {1'b0, den_reg};
            quo_next = {quo_reg[WIDTH-2:0], 1'b1};
         end else begin
            rem_next = trial;
            quo_next = {quo_reg[WIDTH-2:0], 1'b0};
         end
         cnt_next = cnt_reg - 1'b1;
         if (cnt_reg == CW'(1)) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rem_reg  <= '0;
         quo_reg  <= '0;
         den_reg  <= '0;
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         rem_reg  <= rem_next;
         quo_reg  <= quo_next;
         den_reg  <= den_next;
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign busy_out = busy_reg;
   assign done_out = done_reg;
   assign quot_out = quo_reg;
endmodule : seq_divider

// >>> stop_pulse_pkg.sv
// Constants shared by the pulse output and precise stop logic.
// Assumes a 100 MHz system clock; out_freq_in and freq_max_in in 0.01 Hz, pulse full scale and pulse frequency in Hz.
package stop_pulse_pkg;
   localparam int CLK_HZ       = 100_000_000;
   localparam int HALF_CLK_HZ  = CLK_HZ / 2;
   localparam int COMP_UNIT_MS = 1;
   localparam int CYC_PER_MS   = CLK_HZ / 1000 * COMP_UNIT_MS;

   localparam logic [5:0] FN_STATUS_LAST = 6'h14;
   localparam logic [5:0] FN_PULSE_REF   = 6'h15;
   localparam logic [5:0] FN_STATUS2_END = 6'h19;
   localparam logic [5:0] FN_PULSE_FB    = 6'h1A;
   localparam logic [5:0] FN_OUTFREQ     = 6'h1B;
   localparam logic [5:0] FN_CURRENT     = 6'h1C;
   localparam logic [5:0] FN_POWER       = 6'h1D;
   localparam logic [5:0] FN_TEMP        = 6'h1E;
   localparam logic [5:0] FN_CTRL_BIT    = 6'h1F;
   localparam logic [5:0] FN_SLEEP       = 6'h20;

   localparam int         CTRL_BIT_POS   = 12;
   localparam logic [13:0] FS_MIN_HZ     = 14'h0096;
   localparam logic [13:0] FS_MAX_HZ     = 14'h2710;
   localparam logic [13:0] FS_DEFAULT_HZ = 14'h1388;
   localparam logic [13:0] FREQ_FLOOR_HZ = 14'h0010;
   localparam logic [23:0] SLEEP_CHZ     = 24'h00000A;
   localparam logic [24:0] TEMP_LO_C     = 25'h0000014;
   localparam logic [24:0] TEMP_HI_C     = 25'h0000064;

   localparam logic [19:0] PRESET_MAX     = 20'hF423F;
   localparam logic [19:0] PRESET_DEFAULT = 20'h186A0;
   localparam logic [6:0]  COMP_MS_MAX    = 7'h64;
   localparam logic [6:0]  COMP_MS_DEFAULT = 7'h0A;
   localparam int          PULSE_IN_MAX_HZ = 67_600;

   typedef enum logic [2:0] {
      SM_RAMP          = 3'b000,
      SM_COUNT_CLEAR   = 3'b001,
      SM_COUNT_CARRY   = 3'b010,
      SM_VEL_HALT      = 3'b011,
      SM_VEL_COUNT_CLR = 3'b100,
      SM_VEL_COUNT_CRY = 3'b101
   } stop_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DELAY = 2'b10,
      ST_RAMP  = 2'b11
   } stop_state_t;
endpackage : stop_pulse_pkg
